/* twu_timer_unit.sv */
`timescale 1ns/1ns
// Overview of operation
// - A started timer decrements first on the next rising edge of its source.
// - The first underflow interval may be up to one source period short.
// - Timer 2 counting the pin advances on the pin's falling edges.
// - The watchdog is active straight after reset.
// - The watchdog is active again after every return from RAM back-up.
module twu_timer_unit #(
  parameter int TW = twu_pkg::TMR_W,
  parameter logic [15:0] WD_CYCLES = twu_pkg::WD_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic counter_input_pin,
  input wire logic ram_backup_return,
  output logic watchdog_reset
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  twu_pkg::twu_ctrl_t ctrl_r;
  twu_pkg::twu_wd_state_t wd_state_r;
  logic [7:0] presc_div_r;
  logic [7:0] presc_cnt_r;
  logic presc_lvl_r;
  logic [TW-1:0] timer_one_reload;
  logic [TW-1:0] t2_base_r;
  logic [TW-1:0] acc_r;
  logic [TW-1:0] t1_cnt;
  logic [TW-1:0] t2_cnt;
  logic t1_uf;
  logic t2_uf;
  logic t1_flag_r;
  logic t2_flag_r;
  logic watchdog_flag;
  logic [15:0] wd_cnt_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_nxt;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_stat;
  logic ld_t1;
  logic ld_t2;
  logic t1_src;
  logic t2_src;
  logic wd_dis;
  logic wd_rst;
  logic wd_expire;
  logic addr_ok;

  assign addr_ok = hsel & htrans[1] & hready;

  // Bus slave: address phase captured, write data applied in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[7:0];
      end
    end
  end

  assign wr_ctrl = wr_pend_r & hit(wr_addr_r, twu_pkg::ADDR_CTRL);
  assign wr_cmd = wr_pend_r & hit(wr_addr_r, twu_pkg::ADDR_CMD);
  assign wr_stat = wr_pend_r & hit(wr_addr_r, twu_pkg::ADDR_STATUS);
  assign ld_t1 = wr_cmd & hwdata[twu_pkg::CMD_LD_T1];
  assign ld_t2 = wr_cmd & hwdata[twu_pkg::CMD_LD_T2];
  assign wd_dis = wr_cmd & hwdata[twu_pkg::CMD_WD_DIS];
  assign wd_rst = wr_cmd & hwdata[twu_pkg::CMD_WD_RST];

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr[7:0])
      twu_pkg::ADDR_CTRL: rd_nxt[5:0] = ctrl_r;
      twu_pkg::ADDR_PRESC: rd_nxt[7:0] = presc_div_r;
      twu_pkg::ADDR_RELOAD: rd_nxt[TW-1:0] = timer_one_reload;
      twu_pkg::ADDR_ACC: rd_nxt[TW-1:0] = acc_r;
      twu_pkg::ADDR_STATUS: begin
        rd_nxt[twu_pkg::ST_T1_UF] = t1_flag_r;
        rd_nxt[twu_pkg::ST_T2_UF] = t2_flag_r;
        rd_nxt[twu_pkg::ST_WD_FLAG] = watchdog_flag;
        rd_nxt[twu_pkg::ST_WD_ON] = (wd_state_r != twu_pkg::WD_STOP);
      end
      twu_pkg::ADDR_WDCNT: rd_nxt[15:0] = wd_cnt_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is set up at the address phase so the answer takes no wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= twu_pkg::CTRL_RST;
      presc_div_r <= twu_pkg::PRESC_RST;
      timer_one_reload <= twu_pkg::RELOAD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[5:0];
      end
      // Changing the ratio while running gives one odd period; halting first is expected.
      if (wr_pend_r && hit(wr_addr_r, twu_pkg::ADDR_PRESC)) begin
        presc_div_r <= hwdata[7:0];
      end
      // A write landing on the underflow edge races the reload; software avoids it.
      if (wr_pend_r && hit(wr_addr_r, twu_pkg::ADDR_RELOAD)) begin
        timer_one_reload <= hwdata[TW-1:0];
      end
    end
  end

  // Prescaler: square wave, one rising edge per 2*(ratio+1) clocks.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_cnt_r <= 8'h00;
      presc_lvl_r <= 1'b0;
    end else if (!ctrl_r.presc_run) begin
      presc_cnt_r <= 8'h00;
      presc_lvl_r <= 1'b0;
    end else if (presc_cnt_r == presc_div_r) begin
      presc_cnt_r <= 8'h00;
      presc_lvl_r <= ~presc_lvl_r;
    end else begin
      presc_cnt_r <= presc_cnt_r + 8'h01;
    end
  end

  // Pin is inverted so that its falling edge is the rising edge the timer looks for.
  assign t1_src = ctrl_r.t1_src_pin ? ~counter_input_pin : presc_lvl_r;

  always_comb begin
    case (ctrl_r.t2_src)
      twu_pkg::SRC_T1_UF: t2_src = t1_uf;
      twu_pkg::SRC_PIN: t2_src = ~counter_input_pin;
      default: t2_src = presc_lvl_r;
    endcase
  end

  // Accumulator transfers; a running timer gives a stale or torn value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= '0;
      t2_base_r <= '1;
    end else begin
      if (wr_pend_r && hit(wr_addr_r, twu_pkg::ADDR_ACC)) begin
        acc_r <= hwdata[TW-1:0];
      end else if (wr_cmd && hwdata[twu_pkg::CMD_RD_T1]) begin
        acc_r <= t1_cnt;
      end else if (wr_cmd && hwdata[twu_pkg::CMD_RD_T2]) begin
        acc_r <= t2_cnt;
      end
      if (ld_t2) begin
        t2_base_r <= acc_r;
      end
    end
  end

  twu_down_timer #(.W(TW)) u_t1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_r.t1_run),
    .src(t1_src),
    .load(ld_t1),
    .load_val(acc_r),
    .reload_val(timer_one_reload),
    .count(t1_cnt),
    .underflow(t1_uf)
  );

  // Timer 2 has no reload register of its own; it restarts from its last loaded value.
  twu_down_timer #(.W(TW)) u_t2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(ctrl_r.t2_run),
    .src(t2_src),
    .load(ld_t2),
    .load_val(acc_r),
    .reload_val(t2_base_r),
    .count(t2_cnt),
    .underflow(t2_uf)
  );

  // Sticky underflow flags, write one to clear; a new underflow wins over the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_flag_r <= 1'b0;
      t2_flag_r <= 1'b0;
    end else begin
      t1_flag_r <= t1_uf | (t1_flag_r & ~(wr_stat & hwdata[twu_pkg::ST_T1_UF]));
      t2_flag_r <= t2_uf | (t2_flag_r & ~(wr_stat & hwdata[twu_pkg::ST_T2_UF]));
    end
  end

  assign wd_expire = (wd_state_r != twu_pkg::WD_STOP) && (wd_cnt_r == 16'h0000);

  // Disable must be followed by restart in the very next command write to stop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_state_r <= twu_pkg::WD_RUN;
    end else if (ram_backup_return) begin
      wd_state_r <= twu_pkg::WD_RUN;
    end else if (wr_cmd) begin
      case (wd_state_r)
        twu_pkg::WD_RUN: begin
          if (wd_dis) begin
            wd_state_r <= twu_pkg::WD_DIS_SEEN;
          end
        end
        twu_pkg::WD_DIS_SEEN: begin
          wd_state_r <= wd_rst ? twu_pkg::WD_STOP : twu_pkg::WD_RUN;
        end
        twu_pkg::WD_STOP: wd_state_r <= twu_pkg::WD_STOP;
        default: wd_state_r <= twu_pkg::WD_RUN;
      endcase
    end
  end

  // First expiry raises the flag; a second one with the flag still set resets the system.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_r <= WD_CYCLES;
      watchdog_flag <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wd_expire & watchdog_flag;
      if (ram_backup_return || wd_rst || wd_expire) begin
        wd_cnt_r <= WD_CYCLES;
      end else if (wd_state_r != twu_pkg::WD_STOP) begin
        wd_cnt_r <= wd_cnt_r - 16'h0001;
      end
      if (wd_expire) begin
        watchdog_flag <= 1'b1;
      end else if (wr_stat && hwdata[twu_pkg::ST_WD_FLAG]) begin
        watchdog_flag <= 1'b0;
      end
    end
  end

  logic seen_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  a_wd_reset_on: assert property (@(posedge hclk) disable iff (!hresetn)
    !seen_r |-> wd_state_r == twu_pkg::WD_RUN && wd_cnt_r == WD_CYCLES)
    else $error("Watchdog not active after reset.");

  a_wd_return_on: assert property (@(posedge hclk) disable iff (!hresetn)
    ram_backup_return |=> wd_state_r == twu_pkg::WD_RUN && wd_cnt_r == WD_CYCLES)
    else $error("Watchdog not active after RAM back-up return.");

  a_wd_pair_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (wd_state_r == twu_pkg::WD_DIS_SEEN && wd_rst && !ram_backup_return)
    |=> wd_state_r == twu_pkg::WD_STOP)
    else $error("Disable and restart pair did not stop the watchdog.");

  a_wd_reset_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_reset |-> $past(watchdog_flag) && $past(wd_cnt_r) == 16'h0000)
    else $error("Watchdog reset without a second expiry.");

  a_t2_pin_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (t2_cnt != $past(t2_cnt) && !$past(ld_t2) && $past(ctrl_r.t2_src) == twu_pkg::SRC_PIN)
    |-> !$past(counter_input_pin) && $past(counter_input_pin, 2))
    else $error("Timer 2 moved without a pin falling edge.");

  a_t1_first_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(ctrl_r.t1_run) && ctrl_r.presc_run && !ctrl_r.t1_src_pin && !ld_t1)
    |-> ##[1:515] (t1_cnt != $past(t1_cnt) || !ctrl_r.t1_run || wr_ctrl))
    else $error("Timer 1 first count came later than one source period.");

  c_t1_underflow: cover property (@(posedge hclk) disable iff (!hresetn) t1_uf);
  c_wd_stopped: cover property (@(posedge hclk) disable iff (!hresetn)
    wd_state_r == twu_pkg::WD_STOP);
  c_wd_reset: cover property (@(posedge hclk) disable iff (!hresetn) watchdog_reset);
  c_t2_pin: cover property (@(posedge hclk) disable iff (!hresetn)
    t2_uf && ctrl_r.t2_src == twu_pkg::SRC_PIN);

endmodule : twu_timer_unit

/* twu_pkg.sv */
package twu_pkg;

  localparam int TMR_W = 8;
  localparam int WD_W = 16;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESC = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_ACC = 8'h0c;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_WDCNT = 8'h18;

  // Command register bit positions.
  localparam int CMD_RD_T1 = 0;
  localparam int CMD_RD_T2 = 1;
  localparam int CMD_LD_T1 = 2;
  localparam int CMD_LD_T2 = 3;
  localparam int CMD_WD_DIS = 4;
  localparam int CMD_WD_RST = 5;

  // Status register bit positions.
  localparam int ST_T1_UF = 0;
  localparam int ST_T2_UF = 1;
  localparam int ST_WD_FLAG = 2;
  localparam int ST_WD_ON = 3;

  // Count source codes.
  localparam logic [1:0] SRC_PRESC = 2'h0;
  localparam logic [1:0] SRC_T1_UF = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;

  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'hff;
  localparam logic [15:0] WD_CYCLES_DEF = 16'hffff;

  typedef struct packed {
    logic [1:0] t2_src;
    logic t1_src_pin;
    logic t2_run;
    logic t1_run;
    logic presc_run;
  } twu_ctrl_t;

  localparam twu_ctrl_t CTRL_RST = '0;

  typedef enum logic [2:0] {
    WD_RUN = 3'b001,
    WD_DIS_SEEN = 3'b010,
    WD_STOP = 3'b100
  } twu_wd_state_t;

endpackage : twu_pkg

/* twu_down_timer.sv */
`timescale 1ns/1ns
module twu_down_timer #(
  parameter int W = twu_pkg::TMR_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic src,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] reload_val,
  output logic [W-1:0] count,
  output logic underflow
);

  logic src_q_r;
  logic tick;

  // A source already high at start is not an edge, so counting waits for the next rise.
  assign tick = run & src & ~src_q_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q_r <= 1'b0;
    end else begin
      src_q_r <= src;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '1;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (load) begin
        count <= load_val;
      end else if (tick) begin
        if (count == '0) begin
          count <= reload_val;
          underflow <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end

  a_dec_on_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (count != $past(count) && !$past(load)) |-> $past(run) && $past(src) && !$past(src_q_r))
    else $error("Timer moved without a source rising edge.");

  a_uf_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && !load && count == '0) |=> underflow && count == $past(reload_val))
    else $error("Underflow did not reload and flag.");

endmodule : twu_down_timer

/* twu_pulse_src.sv */
`timescale 1ns/1ns
module twu_pulse_src #(
  parameter int HALF = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  output logic pin,
  output logic busy
);
  int left;
  int ph;

  // The pin idles high, so only the falls made here can count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin <= 1'b1;
      busy <= 1'b0;
      left <= 0;
      ph <= 0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      left <= n_pulses;
      ph <= 0;
    end else if (busy && ph < HALF - 1) begin
      ph <= ph + 1;
    end else if (busy) begin
      ph <= 0;
      if (pin && left == 0) begin
        busy <= 1'b0;
      end else if (pin) begin
        pin <= 1'b0;
      end else begin
        pin <= 1'b1;
        left <= left - 1;
      end
    end
  end
endmodule : twu_pulse_src

/* twu_timer_unit_tb_top.sv */
`timescale 1ns/1ns
module twu_timer_unit_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ram_backup_return = 1'b0;
  logic pgo = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] pn = 8'h00;
  logic [31:0] hrdata, rd;
  logic hready, hreadyout, hresp, pin, wd_rst, pbusy;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 35;
  int wd_pulses = 0;

  assign hready = hreadyout;

  twu_timer_unit #(.WD_CYCLES(16'h0020)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .counter_input_pin(pin), .ram_backup_return(ram_backup_return), .watchdog_reset(wd_rst));

  twu_pulse_src #(.HALF(6)) pm_u (.hclk(hclk), .hresetn(hresetn), .go(pgo), .n_pulses(pn),
    .pin(pin), .busy(pbusy));

  initial begin
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (wd_rst === 1'b1) wd_pulses++;
  end

  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask : chk32

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      fail("bus wait ran out");
      report_and_stop;
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
    if (hresp !== 1'b0) fail("response not okay");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rdr

  // Reference counter: decrement per source edge, reload on the edge after zero.
  function automatic int tmodel(input int c, input int rl, input int n, output bit uf);
    uf = 1'b0;
    repeat (n) begin
      if (c == 0) begin
        c = rl;
        uf = 1'b1;
      end else c--;
    end
    return c;
  endfunction : tmodel

  // Fires n falls on the pin, waits for the source to idle, then lets the timers settle.
  task automatic pulses(input int n);
    int k;
    pn <= n[7:0];
    pgo <= 1'b1;
    @(posedge hclk);
    pgo <= 1'b0;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (pbusy === 1'b1 && k < 400);
    if (k >= 400) begin
      fail("pulse source hung");
      report_and_stop;
    end
    repeat (4) @(posedge hclk);
  endtask : pulses

  // Timer 2 counts timer 1 underflows while timer 1 counts pin falls.
  task automatic cascade_test;
    int c1, c2, r1, r2;
    bit uf, uf2;
    c1 = {$random(seed)} % 4;
    r1 = {$random(seed)} % 4;
    r2 = {$random(seed)} % 4;
    c2 = r2;
    wr(twu_pkg::ADDR_CTRL, 32'h18);
    wr(twu_pkg::ADDR_RELOAD, r1);
    wr(twu_pkg::ADDR_ACC, c1);
    wr(twu_pkg::ADDR_CMD, 32'h4);
    wr(twu_pkg::ADDR_ACC, r2);
    wr(twu_pkg::ADDR_CMD, 32'h8);
    wr(twu_pkg::ADDR_CTRL, 32'h1e);
    pulses(10);
    wr(twu_pkg::ADDR_CTRL, 32'h18);
    for (int j = 0; j < 10; j++) begin
      c1 = tmodel(c1, r1, 1, uf);
      if (uf) c2 = tmodel(c2, r2, 1, uf2);
    end
    wr(twu_pkg::ADDR_CMD, 32'h1);
    rdr(twu_pkg::ADDR_ACC);
    chk32(rd, c1, "cascade timer 1 count");
    wr(twu_pkg::ADDR_CMD, 32'h2);
    rdr(twu_pkg::ADDR_ACC);
    chk32(rd, c2, "cascade timer 2 count");
    $display("test cascade done");
  endtask : cascade_test

  task automatic pin_timer(input int t);
    int st, rl, n, k;
    bit uf;
    logic [31:0] src, runb;
    src = (t == 1) ? 32'h08 : 32'h20;
    runb = (t == 1) ? 32'h02 : 32'h04;
    for (int i = 0; i < 4; i++) begin
      st = {$random(seed)} % 8;
      rl = {$random(seed)} % 16;
      n = (i == 0) ? 0 : {$random(seed)} % 13;
      wr(twu_pkg::ADDR_CTRL, src);
      wr(twu_pkg::ADDR_RELOAD, rl);
      if (t == 2) rl = st;
      wr(twu_pkg::ADDR_ACC, st);
      wr(twu_pkg::ADDR_CMD, 32'h1 << (t + 1));
      wr(twu_pkg::ADDR_STATUS, 32'h3);
      wr(twu_pkg::ADDR_CTRL, src | runb);
      pulses(n);
      wr(twu_pkg::ADDR_CTRL, src);
      wr(twu_pkg::ADDR_CMD, 32'h1 << (t - 1));
      rdr(twu_pkg::ADDR_ACC);
      chk32(rd, tmodel(st, rl, n, uf), "timer count");
      rdr(twu_pkg::ADDR_STATUS);
      chk32((rd >> (t - 1)) & 32'h1, {31'h0, uf}, "underflow flag");
    end
    $display("test pin timer %0d done", t);
  endtask : pin_timer

  initial begin
    int k, p;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdr(twu_pkg::ADDR_STATUS);
    chk32(rd & 32'h8, 32'h8, "watchdog active at reset");
    rdr(twu_pkg::ADDR_RELOAD);
    chk32(rd, 32'hff, "reload reset value");
    rdr(twu_pkg::ADDR_CTRL);
    chk32(rd, 32'h0, "ctrl reset value");
    wr(8'h1c, 32'hffffffff);
    rdr(8'h1c);
    chk32(rd, 32'h0, "unmapped read");
    $display("test reset values done");
    k = 0;
    while (wd_pulses == 0 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 200) begin
      fail("watchdog pulse wait ran out");
      report_and_stop;
    end
    chk32(wd_pulses, 32'h1, "watchdog expiry pulse");
    wr(twu_pkg::ADDR_CMD, 32'h10);
    wr(twu_pkg::ADDR_CMD, 32'h20);
    wr(twu_pkg::ADDR_STATUS, 32'h4);
    rdr(twu_pkg::ADDR_STATUS);
    chk32(rd & 32'hc, 32'h0, "watchdog stopped");
    p = wd_pulses;
    repeat (150) @(posedge hclk);
    chk32(wd_pulses - p, 32'h0, "no pulse while stopped");
    rdr(twu_pkg::ADDR_WDCNT);
    chk32(rd, 32'h20, "watchdog count held");
    ram_backup_return <= 1'b1;
    @(posedge hclk);
    ram_backup_return <= 1'b0;
    rdr(twu_pkg::ADDR_STATUS);
    chk32(rd & 32'h8, 32'h8, "active after back-up");
    // An unrelated command between the pair breaks it.
    wr(twu_pkg::ADDR_CMD, 32'h10);
    wr(twu_pkg::ADDR_CMD, 32'h01);
    wr(twu_pkg::ADDR_CMD, 32'h20);
    rdr(twu_pkg::ADDR_STATUS);
    chk32(rd & 32'h8, 32'h8, "broken pair keeps watchdog");
    wr(twu_pkg::ADDR_CMD, 32'h10);
    wr(twu_pkg::ADDR_CMD, 32'h20);
    wr(twu_pkg::ADDR_STATUS, 32'h4);
    rdr(twu_pkg::ADDR_STATUS);
    chk32(rd & 32'hc, 32'h0, "stopped after back-up");
    $display("test watchdog done");
    pin_timer(1);
    pin_timer(2);
    wr(twu_pkg::ADDR_CTRL, 32'h0);
    wr(twu_pkg::ADDR_PRESC, 32'h1);
    rdr(twu_pkg::ADDR_PRESC);
    chk32(rd, 32'h1, "ratio readback");
    wr(twu_pkg::ADDR_ACC, 32'd200);
    wr(twu_pkg::ADDR_CMD, 32'h4);
    wr(twu_pkg::ADDR_CTRL, 32'h3);
    repeat (100) @(posedge hclk);
    wr(twu_pkg::ADDR_CTRL, 32'h0);
    wr(twu_pkg::ADDR_CMD, 32'h1);
    rdr(twu_pkg::ADDR_ACC);
    // About 103 clocks run at one edge per 4 clocks; start skew may cost one edge.
    chk32({31'h0, rd >= 32'd172 && rd <= 32'd176}, 32'h1, "prescaled count");
    $display("test prescaler done");
    cascade_test;
    report_and_stop;
  end
endmodule : twu_timer_unit_tb_top
